// ==== hw/wake_on_radio_timer_config.sv ====
// sleep timer configuration registers, slow tick generation and event timers
//
// Behaviour
// - A sleep clock divide enable bit, reset to one, divides the slow timer clock in sleep.
// - The third event select gives off for 00 and 2^15, 2^18, 2^21 slow periods otherwise.
// - The calibration mode field resets to 00; 00 and 01 disable, 10 enables calibration.
// - Mode 11 calibrates on every fourth power-up transition from idle to receive.
// - A power down bit, reset to one, stops the slow oscillator; zero runs it.
// - The first event timeout high byte resets to zero and scales with the resolution.
// - The first event timeout low byte resets to zero and joins the high byte.
// - A two-bit resolution field multiplies the first event period by 2^(5*code).
`timescale 1ns/10ps
`default_nettype none
`include "wake_timer_cfg.svh"
module wake_on_radio_timer_config #(
    parameter int RC_TICK_DIV = `RC_TICK_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleepMode,
    input wire logic idleToRxPowerUp,
    output var logic slowOscEnable,
    output var logic timerTick,
    output var logic slowOscCalibrate,
    output var logic event0Expired,
    output var logic event2Expired
);
    import wake_timer_pkg::*;

    // ***********************************
    // register file
    // ***********************************
    reg_byte_t sleepTimerConfig;
    reg_byte_t sleepTimerConfigCompanion;
    reg_byte_t event0TimeoutHigh;
    reg_byte_t event0TimeoutLow;
    reg_byte_t next_sleepTimerConfig;
    reg_byte_t next_sleepTimerConfigCompanion;
    reg_byte_t next_event0TimeoutHigh;
    reg_byte_t next_event0TimeoutLow;

    // write channel state
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [7:0] wByte;
    logic wLane;
    logic next_awHeld;
    logic next_wHeld;
    logic [7:0] next_awAddr;
    logic [7:0] next_wByte;
    logic next_wLane;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;

    // read channel state
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // decoded fields
    logic sleepDivideEnable;
    logic [1:0] thirdEventSelect;
    logic [1:0] calibrationMode;
    logic slowOscPowerDown;
    logic [1:0] timerResolution;
    logic doWrite;
    logic writeHit;
    logic readHit;
    reg_byte_t readByte;
    reg_byte_t statusByte;

    assign sleepDivideEnable = sleepTimerConfig[`DIV_EN_BIT];
    assign thirdEventSelect = sleepTimerConfig[`EV2_SEL_MSB:`EV2_SEL_LSB];
    assign calibrationMode = sleepTimerConfig[`CAL_MSB:`CAL_LSB];
    assign slowOscPowerDown = sleepTimerConfig[`PD_BIT];
    assign timerResolution = sleepTimerConfigCompanion[`RES_MSB:`RES_LSB];

    // address and data may arrive in either order; both are held until the write lands
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wByte = wByte;
        next_wLane = wLane;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wByte = s_axi_wdata[7:0];
            next_wLane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = writeHit ? `RESP_OKAY : `RESP_SLVERR;
        end
        // no new beat is taken while a response waits, so one write is in flight
        next_awready = !next_awHeld && !next_bvalid;
        next_wready = !next_wHeld && !next_bvalid;
    end

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign writeHit = (awAddr[7:2] == 6'(`ADDR_SLEEP_CFG >> 2)) ||
                      (awAddr[7:2] == 6'(`ADDR_SLEEP_CFG_COMP >> 2)) ||
                      (awAddr[7:2] == 6'(`ADDR_EV0_HIGH >> 2)) ||
                      (awAddr[7:2] == 6'(`ADDR_EV0_LOW >> 2)) ||
                      (awAddr[7:2] == 6'(`ADDR_STATUS >> 2));

    // register updates; only byte lane 0 carries data, other lanes are dropped
    always_comb begin
        next_sleepTimerConfig = sleepTimerConfig;
        next_sleepTimerConfigCompanion = sleepTimerConfigCompanion;
        next_event0TimeoutHigh = event0TimeoutHigh;
        next_event0TimeoutLow = event0TimeoutLow;
        if (doWrite && wLane) begin
            unique case (awAddr[7:2])
                6'(`ADDR_SLEEP_CFG >> 2): begin
                    // top bits stay zero whatever is written
                    next_sleepTimerConfig = wByte & `SLEEP_CFG_WMASK;
                end
                6'(`ADDR_SLEEP_CFG_COMP >> 2): begin
                    next_sleepTimerConfigCompanion = wByte;
                end
                6'(`ADDR_EV0_HIGH >> 2): begin
                    next_event0TimeoutHigh = wByte;
                end
                6'(`ADDR_EV0_LOW >> 2): begin
                    next_event0TimeoutLow = wByte;
                end
                default: begin
                    next_sleepTimerConfig = sleepTimerConfig;
                end
            endcase
        end
    end

    // ***********************************
    // read channel
    // ***********************************
    logic [1:0] calibrationCount;

    // status shows what the timer core is doing right now
    always_comb begin
        statusByte = '0;
        statusByte[`ST_OSC_RUN_BIT] = slowOscEnable;
        statusByte[`ST_DIV_ACT_BIT] = sleepMode && sleepDivideEnable;
        statusByte[`ST_CAL_CNT_LSB +: 2] = calibrationCount;
        statusByte[`ST_EV2_ON_BIT] = thirdEventSelect != `EV2_OFF;
    end

    // read decode; unmapped addresses answer an error with zero data
    always_comb begin
        readHit = 1'b1;
        readByte = '0;
        unique case (s_axi_araddr[7:2])
            6'(`ADDR_SLEEP_CFG >> 2): readByte = sleepTimerConfig;
            6'(`ADDR_SLEEP_CFG_COMP >> 2): readByte = sleepTimerConfigCompanion;
            6'(`ADDR_EV0_HIGH >> 2): readByte = event0TimeoutHigh;
            6'(`ADDR_EV0_LOW >> 2): readByte = event0TimeoutLow;
            6'(`ADDR_STATUS >> 2): readByte = statusByte;
            default: readHit = 1'b0;
        endcase
    end

    // one read in flight: arready drops until the data beat is accepted
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = {24'h000000, readByte};
            next_rresp = readHit ? `RESP_OKAY : `RESP_SLVERR;
        end
        next_arready = !next_rvalid;
    end

    // bus and register flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleepTimerConfig <= `SLEEP_CFG_RESET;
            sleepTimerConfigCompanion <= `SLEEP_CFG_COMP_RESET;
            event0TimeoutHigh <= `EV0_BYTE_RESET;
            event0TimeoutLow <= `EV0_BYTE_RESET;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wByte <= '0;
            wLane <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            sleepTimerConfig <= next_sleepTimerConfig;
            sleepTimerConfigCompanion <= next_sleepTimerConfigCompanion;
            event0TimeoutHigh <= next_event0TimeoutHigh;
            event0TimeoutLow <= next_event0TimeoutLow;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wByte <= next_wByte;
            wLane <= next_wLane;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ***********************************
    // slow oscillator and tick generation
    // ***********************************
    logic [15:0] rcDivCount;
    logic [6:0] sleepDivCount;
    logic [15:0] next_rcDivCount;
    logic [6:0] next_sleepDivCount;
    logic next_slowOscEnable;
    logic next_timerTick;
    logic rcTick;

    assign rcTick = slowOscEnable && (rcDivCount == 16'(RC_TICK_DIV - 1));

    // the oscillator is a divider here; power down clears its count to zero, so no ticks leak out
    always_comb begin
        next_slowOscEnable = !slowOscPowerDown;
        next_rcDivCount = rcDivCount;
        next_sleepDivCount = sleepDivCount;
        next_timerTick = 1'b0;
        if (!slowOscEnable) begin
            next_rcDivCount = '0;
        end else if (rcTick) begin
            next_rcDivCount = '0;
        end else begin
            next_rcDivCount = 16'(rcDivCount + 1'b1);
        end
        // division only applies in sleep; awake the timer runs at full slow rate
        if (sleepMode && sleepDivideEnable) begin
            if (rcTick) begin
                next_sleepDivCount = 7'(sleepDivCount + 1'b1);
                next_timerTick = sleepDivCount == `SLEEP_DIV_LAST;
            end
        end else begin
            next_sleepDivCount = '0;
            next_timerTick = rcTick;
        end
    end

    // oscillator flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rcDivCount <= '0;
            sleepDivCount <= '0;
            slowOscEnable <= 1'b0;
            timerTick <= 1'b0;
        end else begin
            rcDivCount <= next_rcDivCount;
            sleepDivCount <= next_sleepDivCount;
            slowOscEnable <= next_slowOscEnable;
            timerTick <= next_timerTick;
        end
    end

    // ***********************************
    // calibration scheduling
    // ***********************************
    logic [1:0] next_calibrationCount;
    logic next_slowOscCalibrate;

    // the count is kept in every mode so switching to mode 11 starts from a known phase
    always_comb begin
        next_calibrationCount = calibrationCount;
        next_slowOscCalibrate = 1'b0;
        if (idleToRxPowerUp) begin
            next_calibrationCount = 2'(calibrationCount + 1'b1);
            unique case (calibrationMode)
                `CAL_EACH: begin
                    // relies on software keeping the oscillator running
                    next_slowOscCalibrate = 1'b1;
                end
                `CAL_EVERY4: begin
                    next_slowOscCalibrate = calibrationCount == `CAL_FOURTH;
                end
                default: begin
                    next_slowOscCalibrate = 1'b0;
                end
            endcase
        end
    end

    // calibration flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            calibrationCount <= '0;
            slowOscCalibrate <= 1'b0;
        end else begin
            calibrationCount <= next_calibrationCount;
            slowOscCalibrate <= next_slowOscCalibrate;
        end
    end

    // ***********************************
    // event timers
    // ***********************************
    period_t event0Period;
    period_t event2Period;
    shift_t resolutionShift;
    shift_t thirdEventExponent;

    // each resolution step is five binary orders of magnitude
    always_comb begin
        unique case (timerResolution)
            2'b00: resolutionShift = `RES_SHIFT_0;
            2'b01: resolutionShift = `RES_SHIFT_1;
            2'b10: resolutionShift = `RES_SHIFT_2;
            2'b11: resolutionShift = `RES_SHIFT_3;
        endcase
        unique case (thirdEventSelect)
            `EV2_SEL_A: thirdEventExponent = `EV2_EXP_A;
            `EV2_SEL_B: thirdEventExponent = `EV2_EXP_B;
            default: thirdEventExponent = `EV2_EXP_C;
        endcase
        event0Period = period_t'({event0TimeoutHigh, event0TimeoutLow}) << resolutionShift;
        event2Period = period_t'(1'b1) << thirdEventExponent;
    end

    // first event runs whenever the oscillator runs and its timeout is nonzero
    event_countdown firstEvent (
        .clk(clk),
        .rst(rst),
        .enable(slowOscEnable),
        .tick(timerTick),
        .period(event0Period),
        .expired(event0Expired)
    );

    // third event is parked by code 00
    event_countdown thirdEvent (
        .clk(clk),
        .rst(rst),
        .enable(slowOscEnable && thirdEventSelect != `EV2_OFF),
        .tick(timerTick),
        .period(event2Period),
        .expired(event2Expired)
    );
endmodule
`default_nettype wire

// ==== common/wake_timer_cfg.svh ====
// register map, field positions, reset values and timing counts of the sleep timer
`ifndef WAKE_TIMER_CFG_SVH
`define WAKE_TIMER_CFG_SVH

// ***********************************
// register byte addresses
// ***********************************
`define ADDR_SLEEP_CFG 8'h00
`define ADDR_SLEEP_CFG_COMP 8'h04
`define ADDR_EV0_HIGH 8'h08
`define ADDR_EV0_LOW 8'h0C
`define ADDR_STATUS 8'h10

// ***********************************
// field positions
// ***********************************
`define DIV_EN_BIT 5
`define EV2_SEL_MSB 4
`define EV2_SEL_LSB 3
`define CAL_MSB 2
`define CAL_LSB 1
`define PD_BIT 0
`define RES_MSB 7
`define RES_LSB 6
`define ST_OSC_RUN_BIT 0
`define ST_DIV_ACT_BIT 1
`define ST_CAL_CNT_LSB 2
`define ST_EV2_ON_BIT 4

// ***********************************
// reset values and masks
// ***********************************
`define SLEEP_CFG_RESET 8'h21
`define SLEEP_CFG_WMASK 8'h3F
`define SLEEP_CFG_COMP_RESET 8'h08
`define EV0_BYTE_RESET 8'h00

// ***********************************
// encodings and counts
// ***********************************
`define EV2_OFF 2'b00
`define EV2_SEL_A 2'b01
`define EV2_SEL_B 2'b10
`define EV2_EXP_A 5'h0F
`define EV2_EXP_B 5'h12
`define EV2_EXP_C 5'h15
`define RES_SHIFT_0 5'h00
`define RES_SHIFT_1 5'h05
`define RES_SHIFT_2 5'h0A
`define RES_SHIFT_3 5'h0F
`define CAL_EACH 2'b10
`define CAL_EVERY4 2'b11
`define CAL_FOURTH 2'h3
`define SLEEP_DIV_LAST 7'h7F
`define RC_TICK_DIV_DEFAULT 6250
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== common/wake_timer_pkg.sv ====
// types shared by the sleep timer configuration block
package wake_timer_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [30:0] period_t;
    typedef logic [4:0] shift_t;
endpackage

// ==== hw/event_countdown.sv ====
// periodic event counter advanced by slow timer ticks
`timescale 1ns/10ps
`default_nettype none
module event_countdown (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic tick,
    input wire wake_timer_pkg::period_t period,
    output var logic expired
);
    import wake_timer_pkg::*;

    period_t count;
    period_t next_count;
    logic next_expired;

    // a zero period never fires, so a cleared timeout parks the event
    always_comb begin
        next_count = count;
        next_expired = 1'b0;
        if (!enable || period == '0) begin
            next_count = '0;
        end else if (tick) begin
            if (count >= period_t'(period - 1'b1)) begin
                next_count = '0;
                next_expired = 1'b1;
            end else begin
                next_count = period_t'(count + 1'b1);
            end
        end
    end

    // state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end
endmodule
`default_nettype wire

// ==== test/wake_on_radio_timer_config_sva.sv ====
// assertions on register answers and timer pulses of the sleep timer block
`timescale 1ns/10ps
`default_nettype none
module wake_on_radio_timer_config_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic idleToRxPowerUp,
    input wire logic slowOscEnable,
    input wire logic timerTick,
    input wire logic slowOscCalibrate,
    input wire logic event0Expired,
    input wire logic event2Expired
);
    logic [7:0] awAddrQ;
    logic [7:0] arAddrQ;
    logic cfgWritten;
    // addresses held because the answers come cycles after the handshakes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awAddrQ <= 8'h00;
            arAddrQ <= 8'h00;
            cfgWritten <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == 6'h00) begin
                cfgWritten <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                arAddrQ <= s_axi_araddr;
            end
        end
    end
    // ***********************************
    // properties
    // ***********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_CFG_RESET_VALUE: assert property (
        s_axi_rvalid && arAddrQ[7:2] == 6'h00 && !cfgWritten |-> s_axi_rdata == 32'h0000_0021)
        else $error("config register read differs from its reset value");
    AST_CFG_TOP_BITS: assert property (
        s_axi_rvalid && arAddrQ[7:2] == 6'h00 |-> s_axi_rdata[7:6] == 2'b00)
        else $error("config register top bits read nonzero");
    AST_BYTE_READ: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data above the byte is nonzero");
    AST_WRITE_RESP: assert property (
        $rose(s_axi_bvalid) |-> s_axi_bresp == ((awAddrQ[7:2] > 6'h04) ? 2'b10 : 2'b00))
        else $error("write response code wrong for the address");
    AST_OSC_ON_AFTER_WRITE: assert property (
        $rose(slowOscEnable) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("oscillator started without a register write");
    AST_TICK_NEEDS_OSC: assert property (
        timerTick |-> slowOscEnable || $past(slowOscEnable) || $past(slowOscEnable, 2))
        else $error("timer tick while the oscillator is down");
    AST_CAL_ON_POWERUP: assert property (
        slowOscCalibrate |-> $past(idleToRxPowerUp))
        else $error("calibration started without a power-up transition");
    AST_EV0_ON_TICK: assert property (
        event0Expired |-> timerTick || $past(timerTick) || $past(timerTick, 2))
        else $error("first event expired away from a timer tick");
    AST_EV2_ON_TICK: assert property (
        event2Expired |-> timerTick || $past(timerTick) || $past(timerTick, 2))
        else $error("third event expired away from a timer tick");
endmodule
bind wake_on_radio_timer_config wake_on_radio_timer_config_sva i_sva (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .idleToRxPowerUp(idleToRxPowerUp), .slowOscEnable(slowOscEnable),
    .timerTick(timerTick), .slowOscCalibrate(slowOscCalibrate),
    .event0Expired(event0Expired), .event2Expired(event2Expired)
);
`default_nettype wire

// ==== test/wake_on_radio_timer_config_tb.sv ====
// self-checking bench of the sleep timer configuration block
`timescale 1ns/10ps
`default_nettype none
`include "wake_timer_cfg.svh"
module wake_on_radio_timer_config_tb;
    localparam int DIV = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awAddr = 8'h00;
    logic [7:0] arAddr = 8'h00;
    logic [31:0] wData = 32'h0000_0000;
    logic [3:0] wStrb = 4'h0;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic sleepMode = 1'b0, idleToRxPowerUp = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, slowOscEnable, timerTick;
    logic slowOscCalibrate, event0Expired, event2Expired;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    int failCount = 0;
    int nTests = 0;
    int calCount = 0;
    // ***********************************
    // clock, device and shared tasks
    // ***********************************
    always #2.5 clk = ~clk;
    wake_on_radio_timer_config #(.RC_TICK_DIV(DIV)) i_dut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .sleepMode(sleepMode), .idleToRxPowerUp(idleToRxPowerUp),
        .slowOscEnable(slowOscEnable), .timerTick(timerTick),
        .slowOscCalibrate(slowOscCalibrate), .event0Expired(event0Expired),
        .event2Expired(event2Expired)
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // write one byte; address and data released each at its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
        logic aDone;
        logic dDone;
        aDone = 1'b0;
        dDone = 1'b0;
        @(posedge clk);
        awAddr <= a;
        wData <= {24'h00_0000, d};
        wStrb <= 4'h1;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aDone && dDone)) begin
            @(posedge clk);
            if (!aDone && awReady) begin
                aDone = 1'b1;
                awValid <= 1'b0;
            end
            if (!dDone && wReady) begin
                dDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        do begin @(posedge clk); end while (bValid !== 1'b1);
        bReady <= 1'b0;
        check("write response", {30'h0, bResp}, {30'h0, exp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] expResp);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin @(posedge clk); end while (arReady !== 1'b1);
        arValid <= 1'b0;
        do begin @(posedge clk); end while (rValid !== 1'b1);
        rReady <= 1'b0;
        check("read data", rData, {24'h00_0000, exp});
        check("read response", {30'h0, rResp}, {30'h0, expResp});
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? event0Expired : timerTick;
    endfunction
    // third gap only: the first two may be cut short by a reconfiguration
    task automatic gap(input int w, input int exp);
        int n;
        n = 0;
        for (int p = 0; p < 3; p++) begin
            n = 0;
            do begin @(posedge clk); n++; end while (pick(w) !== 1'b1 && n < 20000);
        end
        check("pulse spacing", n, exp);
    endtask
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_reset;
        check("osc enable", slowOscEnable, 1'b0);
        rd(`ADDR_SLEEP_CFG, 8'h21, `RESP_OKAY);
        rd(`ADDR_EV0_HIGH, 8'h00, `RESP_OKAY);
        rd(`ADDR_EV0_LOW, 8'h00, `RESP_OKAY);
        rd(`ADDR_SLEEP_CFG_COMP, 8'h08, `RESP_OKAY);
    endtask
    task automatic t_regs;
        wr(`ADDR_SLEEP_CFG, 8'hDE, `RESP_OKAY);
        rd(`ADDR_SLEEP_CFG, 8'h1E, `RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_SLEEP_CFG, {3'b001, c[1:0], 3'b001}, `RESP_OKAY);
            rd(`ADDR_SLEEP_CFG, {3'b001, c[1:0], 3'b001}, `RESP_OKAY);
        end
        wr(`ADDR_EV0_HIGH, 8'h5A, `RESP_OKAY);
        wr(`ADDR_EV0_LOW, 8'hA5, `RESP_OKAY);
        rd(`ADDR_EV0_HIGH, 8'h5A, `RESP_OKAY);
        rd(`ADDR_EV0_LOW, 8'hA5, `RESP_OKAY);
        wr(8'h20, 8'h00, `RESP_SLVERR);
        rd(8'h20, 8'h00, `RESP_SLVERR);
        wr(`ADDR_SLEEP_CFG, 8'h01, `RESP_OKAY);
    endtask
    // power cycling the oscillator clears the counters before each period
    task automatic t_ev0(input logic [7:0] h, input logic [7:0] l, input logic [1:0] res,
                         input int ticks);
        wr(`ADDR_SLEEP_CFG, 8'h01, `RESP_OKAY);
        wr(`ADDR_EV0_HIGH, h, `RESP_OKAY);
        wr(`ADDR_EV0_LOW, l, `RESP_OKAY);
        wr(`ADDR_SLEEP_CFG_COMP, {res, 6'h08}, `RESP_OKAY);
        wr(`ADDR_SLEEP_CFG, 8'h00, `RESP_OKAY);
        gap(0, ticks * DIV);
        check("osc enable", slowOscEnable, 1'b1);
    endtask
    task automatic t_div;
        int n;
        n = 0;
        wr(`ADDR_SLEEP_CFG, 8'h20, `RESP_OKAY);
        gap(1, DIV);
        sleepMode <= 1'b1;
        gap(1, 128 * DIV);
        wr(`ADDR_SLEEP_CFG, 8'h00, `RESP_OKAY);
        gap(1, DIV);
        sleepMode <= 1'b0; // woken by the sleep input, never by chip select
        repeat (2000) begin
            @(posedge clk);
            #1;
            n += (event2Expired === 1'b1);
        end
        check("third event while off", n, 0);
    endtask
    task automatic pulse_rx(input logic exp);
        @(posedge clk);
        idleToRxPowerUp <= 1'b1;
        @(posedge clk);
        idleToRxPowerUp <= 1'b0;
        #1;
        check("calibration start", slowOscCalibrate, exp);
        calCount++;
    endtask
    task automatic t_cal;
        for (int m = 0; m < 4; m++) begin
            wr(`ADDR_SLEEP_CFG, {5'h00, m[1:0], 1'b0}, `RESP_OKAY); // osc kept on
            for (int i = 0; i < 5; i++) begin
                pulse_rx(m == 2 || (m == 3 && calCount % 4 == 3));
            end
            rd(`ADDR_STATUS, {4'h0, calCount[1:0], 2'b01}, `RESP_OKAY);
        end
    endtask
    // hang guard, well beyond the expected run length
    initial begin
        repeat (100000) @(posedge clk);
        failCount++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
        t_regs;
        t_ev0(8'h00, 8'h03, 2'b00, 3);
        t_ev0(8'h00, 8'h01, 2'b01, 32);
        t_ev0(8'h01, 8'h00, 2'b00, 256);
        t_ev0(8'h00, 8'h02, 2'b10, 2048);
        t_div;
        t_cal;
        tally_and_finish;
    end
endmodule
`default_nettype wire
